// ===== dvc_core.sv
// Playback volume and dynamic range compressor with its control registers
`timescale 1ns/10ps

// Summary of operation
// - Right gain register holds a signed code in half-decibel steps.
// - Code 0x30 gives +24 dB, each lower code half a decibel less.
// - Code 0xFF gives -0.5 dB, continuing down in two's complement.
// - Code 0x81 gives -63.5 dB; 0x80 is reserved, can be written, and acts as 0x81.
// - Right gain resets to zero, which is unity gain.
// - Control one bit 6 enables compression on the left channel, reset clear.
// - Control one bit 5 enables compression on the right channel, reset clear.
// - Three-bit threshold, -3 to -21 dB in 3 dB steps, resets to -12 dB.
// - Two-bit hysteresis of 0 to 3 dB, resets to 3 dB.
// - Reserved bits take only reset values and read back those values.
// - Hold code zero disables the compressor hold.
// - Hold codes 1 to 12 give 32 word clocks doubled per code.
// - Hold codes 13 to 15 give 98304, 131072 and 163840 word clocks.
// - Hold code resets to 7, a hold of 2048 word clocks.
// - Gain moves one step per sample, per two samples, or jumps.
module dvc_core (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic samp_valid,
    output logic samp_ready,
    input wire dvc_pkg::dvc_frame_type samp_data,
    input wire logic wclk_pin,
    input wire logic [7:0] left_gain,
    input wire logic [1:0] soft_step,
    output dvc_pkg::dvc_frame_type out_data,
    output logic out_valid,
    output logic [1:0] drc_active
);

    dvc_pkg::dvc_core_state_type st_r;
    dvc_pkg::dvc_core_state_type st_nxt;
    dvc_pkg::dvc_frame_type head;
    logic head_valid;
    logic tick;
    logic [1:0] drc_en;
    logic [1:0] over;
    logic [1:0] under;
    logic [1:0][7:0] target;
    logic [1:0][23:0] samp_in;
    logic [1:0][23:0] samp_out;
    logic [23:0] thr_lvl;
    logic [23:0] rel_lvl;
    logic [39:0] rel_prod;
    logic [17:0] hold_load;
    logic step_go;

    // ************************************************************
    // Sample buffer, drained one frame per word clock
    // ************************************************************
    dvc_fifo #(
        .WIDTH($bits(dvc_pkg::dvc_frame_type)),
        .DEPTH(dvc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(samp_valid),
        .in_ready(samp_ready),
        .in_data(samp_data),
        .out_valid(head_valid),
        .out_ready(tick),
        .out_data(head)
    );

    // Word clock edge after the synchroniser
    assign tick = st_r.wsync[1] && !st_r.wprev;

    // Control fields
    assign drc_en[0] = st_r.ctl1[dvc_pkg::CTL1_LEFT_EN];
    assign drc_en[1] = st_r.ctl1[dvc_pkg::CTL1_RIGHT_EN];
    assign thr_lvl = dvc_pkg::THR_TAB[st_r.ctl1[dvc_pkg::CTL1_THR_LSB +: 3]];
    assign rel_prod = thr_lvl * dvc_pkg::HYS_TAB[st_r.ctl1[dvc_pkg::CTL1_HYS_LSB +: 2]];
    assign rel_lvl = rel_prod[dvc_pkg::HYS_FRAC +: 24];
    assign hold_load = dvc_pkg::hold_len(st_r.ctl2[dvc_pkg::CTL2_HOLD_LSB +: 4]);
    assign target[0] = dvc_pkg::clamp_gain(left_gain);
    assign target[1] = dvc_pkg::clamp_gain(st_r.rgain);
    assign samp_in[0] = head_valid ? head.left : '0;
    assign samp_in[1] = head_valid ? head.right : '0;

    // Soft-step pacing
    always_comb begin
        case (dvc_pkg::dvc_step_type'(soft_step))
            dvc_pkg::DVC_STEP_ONE: step_go = 1'b1;
            dvc_pkg::DVC_STEP_TWO: step_go = st_r.half;
            default: step_go = 1'b0;
        endcase
    end

    // ************************************************************
    // Per-channel gain and level detection
    // ************************************************************
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [8:0] eff;
        logic [7:0] idx;
        logic [7:0] quot;
        logic [7:0] rem;
        logic [4:0] shamt;
        logic signed [40:0] prod;
        logic signed [40:0] shifted;
        logic [23:0] mag;
        logic [23:0] sat;

        // Effective gain is the volume less the compressor cut
        always_comb begin
            eff = 9'($signed(st_r.cur[ch])) - $signed({3'b000, st_r.red[ch]});
            if (eff < $signed({1'b1, dvc_pkg::GAIN_MIN})) begin
                eff = $signed({1'b1, dvc_pkg::GAIN_MIN});
            end
        end

        // Octave and half-decibel position of the gain
        assign idx = 8'(eff + $signed({1'b0, dvc_pkg::GAIN_OFS}));
        assign quot = idx / dvc_pkg::GAIN_OCT;
        assign rem = idx % dvc_pkg::GAIN_OCT;
        assign shamt = dvc_pkg::SHIFT_BASE - quot[4:0];
        assign prod = $signed(samp_in[ch]) * $signed({1'b0, dvc_pkg::MANT_TAB[rem[3:0]]});
        assign shifted = prod >>> shamt;

        // Saturate to the sample width
        always_comb begin
            if ((&shifted[40:23]) || !(|shifted[40:23])) begin
                sat = shifted[23:0];
            end else if (shifted[40]) begin
                sat = dvc_pkg::SAT_NEG;
            end else begin
                sat = dvc_pkg::SAT_POS;
            end
        end
        assign samp_out[ch] = sat;

        // Level against threshold and release point
        assign mag = samp_out[ch][23] ? 24'(-samp_out[ch]) : samp_out[ch];
        assign over[ch] = drc_en[ch] && (mag > thr_lvl);
        assign under[ch] = mag < rel_lvl;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.wsync = {st_r.wsync[0], wclk_pin};
        st_nxt.wprev = st_r.wsync[1];
        st_nxt.ovalid = 1'b0;
        st_nxt.rvalid = reg_rd;
        // Register writes
        if (reg_wr) begin
            if (reg_addr == dvc_pkg::ADDR_RGAIN) begin
                st_nxt.rgain = reg_wdata;
            end else if (reg_addr == dvc_pkg::ADDR_CTL1) begin
                st_nxt.ctl1 = reg_wdata & dvc_pkg::CTL1_WMASK;
            end else if (reg_addr == dvc_pkg::ADDR_CTL2) begin
                st_nxt.ctl2 = reg_wdata & dvc_pkg::CTL2_WMASK;
            end
        end
        // Register reads
        if (reg_rd) begin
            if (reg_addr == dvc_pkg::ADDR_RGAIN) begin
                st_nxt.rdata = st_r.rgain;
            end else if (reg_addr == dvc_pkg::ADDR_CTL1) begin
                st_nxt.rdata = st_r.ctl1;
            end else if (reg_addr == dvc_pkg::ADDR_CTL2) begin
                st_nxt.rdata = st_r.ctl2;
            end else begin
                st_nxt.rdata = dvc_pkg::RDATA_NONE;
            end
        end
        // Per word clock: output, soft step and compressor
        if (tick) begin
            st_nxt.half = !st_r.half;
            st_nxt.ovalid = 1'b1;
            st_nxt.odata.left = samp_out[0];
            st_nxt.odata.right = samp_out[1];
            for (int c = 0; c < 2; c++) begin
                if (!step_go && (soft_step[1] == 1'b1)) begin
                    st_nxt.cur[c] = target[c];
                end else if (step_go && ($signed(st_r.cur[c]) < $signed(target[c]))) begin
                    st_nxt.cur[c] = st_r.cur[c] + dvc_pkg::ONE_STEP;
                end else if (step_go && ($signed(st_r.cur[c]) > $signed(target[c]))) begin
                    st_nxt.cur[c] = st_r.cur[c] - dvc_pkg::ONE_STEP;
                end
                if (!drc_en[c]) begin
                    st_nxt.red[c] = '0;
                    st_nxt.hold[c] = '0;
                end else if (over[c]) begin
                    if (st_r.red[c] != dvc_pkg::RED_MAX) begin
                        st_nxt.red[c] = st_r.red[c] + 6'h01;
                    end
                    st_nxt.hold[c] = hold_load;
                end else if (st_r.hold[c] != '0) begin
                    st_nxt.hold[c] = (hold_load == '0) ? '0 : st_r.hold[c] - 1'b1;
                end else if (under[c] && (st_r.red[c] != '0)) begin
                    st_nxt.red[c] = st_r.red[c] - 6'h01;
                end
            end
        end
    end

    // State register with documented reset values
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.rgain <= dvc_pkg::RGAIN_RST;
            st_r.ctl1 <= dvc_pkg::CTL1_RST;
            st_r.ctl2 <= dvc_pkg::CTL2_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign out_data = st_r.odata;
    assign out_valid = st_r.ovalid;
    assign drc_active[0] = (st_r.red[0] != '0);
    assign drc_active[1] = (st_r.red[1] != '0);

    // ************************************************************
    // Checks
    // ************************************************************
    a_gain_reset_zero : assert property (@(posedge clk_sys)
        $rose(rst_b) |-> (st_r.rgain == dvc_pkg::RGAIN_RST) && (st_r.ctl2 == dvc_pkg::CTL2_RST))
        else $error("Reset values wrong");

    a_ctl1_resv_read : assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && (reg_addr == dvc_pkg::ADDR_CTL1) |=> reg_rvalid && !reg_rdata[7])
        else $error("Control one reserved bit reads set");

    a_ctl2_resv_read : assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && (reg_addr == dvc_pkg::ADDR_CTL2) |=> (reg_rdata[7] == 1'b0)
        && (reg_rdata[2:0] == 3'b000))
        else $error("Control two reserved bits read set");

    a_left_disabled : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && !st_r.ctl1[dvc_pkg::CTL1_LEFT_EN] |=> !drc_active[0] ##1 !drc_active[0])
        else $error("Left compressor active while disabled");

    a_right_disabled : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && !st_r.ctl1[dvc_pkg::CTL1_RIGHT_EN] |=> (st_r.red[1] == '0))
        else $error("Right compressor active while disabled");

    a_hold_blocks_rel : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && drc_en[1] && (st_r.hold[1] != '0) |=> (st_r.red[1] >= $past(st_r.red[1])))
        else $error("Gain restored during hold");

    a_hold_reload : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && over[1] |=> (st_r.hold[1] == $past(hold_load)))
        else $error("Hold not reloaded on attack");

    a_hold_off_zero : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && (st_r.ctl2[6:3] == dvc_pkg::HOLD_OFF) |=> (st_r.hold[1] == '0))
        else $error("Hold runs while disabled");

    a_tick_only : assert property (@(posedge clk_sys) disable iff (!rst_b)
        !tick |=> $stable(st_r.red) && $stable(st_r.cur))
        else $error("Compressor moved without word clock");

    a_jump_mode : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && (soft_step == dvc_pkg::DVC_STEP_JUMP) |=> (st_r.cur[1] == $past(target[1])))
        else $error("Jump mode did not reach target");

    a_single_step : assert property (@(posedge clk_sys) disable iff (!rst_b)
        tick && (soft_step == dvc_pkg::DVC_STEP_ONE) && (st_r.cur[1] != target[1])
        |=> (st_r.cur[1] == $past(st_r.cur[1]) + 8'h01)
        || (st_r.cur[1] == $past(st_r.cur[1]) - 8'h01))
        else $error("Soft step size wrong");

    a_max_boost : assert property (@(posedge clk_sys) disable iff (!rst_b)
        $signed(st_r.cur[1]) <= $signed(dvc_pkg::GAIN_MAX))
        else $error("Gain above maximum boost");

    a_hold_log_top : assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_r.ctl2[dvc_pkg::CTL2_HOLD_LSB +: 4] == 4'hc) |-> (hold_load == 18'h10000))
        else $error("Hold length at code twelve wrong");

    a_hold_lin_top : assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_r.ctl2[dvc_pkg::CTL2_HOLD_LSB +: 4] == 4'hf) |-> (hold_load == 18'h28000))
        else $error("Longest hold length wrong");

    c_attack : cover property (@(posedge clk_sys) disable iff (!rst_b)
        tick && over[1]);
    c_release : cover property (@(posedge clk_sys) disable iff (!rst_b)
        drc_active[1] ##1 !drc_active[1]);
    c_fifo_full : cover property (@(posedge clk_sys) disable iff (!rst_b)
        samp_valid && !samp_ready);

endmodule : dvc_core

// ===== dvc_pkg.sv
// Constants, register map and carrier types of the playback volume and compressor block
package dvc_pkg;

    // ************************************************************
    // Sample format
    // ************************************************************
    localparam int SAMP_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam logic [23:0] SAT_POS = 24'h7fffff;
    localparam logic [23:0] SAT_NEG = 24'h800000;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_RGAIN = 8'h42;
    localparam logic [7:0] ADDR_CTL1 = 8'h44;
    localparam logic [7:0] ADDR_CTL2 = 8'h45;
    localparam logic [7:0] RGAIN_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h0f;
    localparam logic [7:0] CTL2_RST = 8'h38;
    // Writable bits; reserved bits always hold zero
    localparam logic [7:0] CTL1_WMASK = 8'h7f;
    localparam logic [7:0] CTL2_WMASK = 8'h78;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    localparam int CTL1_LEFT_EN = 6;
    localparam int CTL1_RIGHT_EN = 5;
    localparam int CTL1_THR_LSB = 2;
    localparam int CTL1_HYS_LSB = 0;
    localparam int CTL2_HOLD_LSB = 3;

    // ************************************************************
    // Gain coding, half-decibel steps
    // ************************************************************
    localparam logic [7:0] GAIN_MAX = 8'h30;
    localparam logic [7:0] GAIN_MIN = 8'h81;
    localparam logic [7:0] GAIN_RSV = 8'h80;
    localparam logic [7:0] GAIN_OFS = 8'h84;
    localparam logic [7:0] GAIN_OCT = 8'h0c;
    localparam logic [4:0] SHIFT_BASE = 5'h19;
    localparam logic [7:0] ONE_STEP = 8'h01;
    // Mantissa 10^(r/40) for r = 0..11 in Q2.14
    localparam logic [11:0][15:0] MANT_TAB = {
        16'h788e, 16'h71cf, 16'h6b71, 16'h656e, 16'h5fc2, 16'h5a67,
        16'h5558, 16'h5092, 16'h4c10, 16'h47cf, 16'h43cb, 16'h4000};

    typedef enum logic [1:0] {
        DVC_STEP_ONE = 2'b00,
        DVC_STEP_TWO = 2'b01,
        DVC_STEP_JUMP = 2'b10,
        DVC_STEP_RSV = 2'b11
    } dvc_step_type;

    // ************************************************************
    // Compressor
    // ************************************************************
    localparam logic [5:0] RED_MAX = 6'h30;
    localparam logic [17:0] HOLD_BASE = 18'h00020;
    localparam logic [17:0] HOLD_LIN_BASE = 18'h10000;
    localparam logic [17:0] HOLD_LIN_STEP = 18'h08000;
    localparam logic [3:0] HOLD_LOG_LAST = 4'hc;
    localparam logic [3:0] HOLD_OFF = 4'h0;
    localparam int HYS_FRAC = 15;
    // Threshold magnitudes, -3 dB .. -21 dB, last two codes equal
    localparam logic [7:0][23:0] THR_TAB = {
        24'h0b6879, 24'h0b6879, 24'h101d57, 24'h16c30f,
        24'h20272d, 24'h2d6a6c, 24'h4027c2, 24'h5a9df7};
    // Release factor for 0..3 dB hysteresis in Q1.15
    localparam logic [3:0][15:0] HYS_TAB = {16'h5a9e, 16'h65ad, 16'h7215, 16'h8000};

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [SAMP_W-1:0] left;
        logic [SAMP_W-1:0] right;
    } dvc_frame_type;

    typedef struct packed {
        logic [1:0] wsync;
        logic wprev;
        logic half;
        logic [7:0] rgain;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0][7:0] cur;
        logic [1:0][5:0] red;
        logic [1:0][17:0] hold;
        dvc_frame_type odata;
        logic ovalid;
    } dvc_core_state_type;

    // Hold length in word clocks for a hold code
    function automatic logic [17:0] hold_len(input logic [3:0] code);
        logic [17:0] len;
        len = '0;
        if (code == HOLD_OFF) begin
            len = '0;
        end else if (code <= HOLD_LOG_LAST) begin
            len = HOLD_BASE << (code - 4'h1);
        end else begin
            len = HOLD_LIN_BASE + 18'(HOLD_LIN_STEP * 18'(code - HOLD_LOG_LAST));
        end
        return len;
    endfunction : hold_len

    // Reserved gain codes fall back to the nearest legal code
    function automatic logic [7:0] clamp_gain(input logic [7:0] code);
        logic [7:0] res;
        res = code;
        if ($signed(code) > $signed(GAIN_MAX)) begin
            res = GAIN_MAX;
        end else if (code == GAIN_RSV) begin
            res = GAIN_MIN;
        end
        return res;
    endfunction : clamp_gain

endpackage : dvc_pkg

// ===== dvc_fifo.sv
// Sample FIFO with valid and ready on both sides
`timescale 1ns/10ps
module dvc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dvc_fifo_state_type;

    dvc_fifo_state_type st_r;
    dvc_fifo_state_type st_nxt;
    logic push;
    logic pop;

    // Honest full and empty flags
    assign in_ready = (st_r.cnt != FULL_CNT);
    assign out_valid = (st_r.cnt != '0);
    assign out_data = st_r.mem[st_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    a_fifo_no_overrun : assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r.cnt <= FULL_CNT)
        else $error("FIFO count above depth");

endmodule : dvc_fifo

// ===== dvc_host_model.sv
// Host model: word clock source and sample stream driver
`timescale 1ns/10ps
module dvc_host_model (
    input wire logic clk_sys,
    input wire logic samp_ready,
    output logic samp_valid,
    output dvc_pkg::dvc_frame_type samp_data,
    output logic wclk_pin
);
    // Idle bus at time zero
    initial begin
        samp_valid = 1'b0;
        samp_data = '0;
        wclk_pin = 1'b0;
    end
    // Offer one frame and hold it until taken
    task automatic push(input dvc_pkg::dvc_frame_type f);
        @(negedge clk_sys);
        samp_valid = 1'b1;
        samp_data = f;
        do @(posedge clk_sys); while (samp_ready !== 1'b1);
        @(negedge clk_sys);
        samp_valid = 1'b0;
        samp_data = ~f; // Released bus shows no stale frame
    endtask : push
    // One word clock period, four clocks high and low
    task automatic tick();
        @(negedge clk_sys);
        wclk_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
        wclk_pin = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : tick
endmodule : dvc_host_model

// ===== dvc_core_tb.sv
// Self-checking bench for the playback volume and compressor block
`timescale 1ns/10ps
module dvc_core_tb;
    typedef struct packed {
        logic chk;
        dvc_pkg::dvc_frame_type f;
    } dvc_note_type;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] soft_step = 2'b10;
    logic [7:0] reg_rdata;
    logic [1:0] drc_active;
    logic reg_rvalid, samp_valid, samp_ready, wclk_pin, out_valid;
    dvc_pkg::dvc_frame_type samp_data, out_data;
    dvc_note_type dq[$];
    dvc_note_type nt;
    logic [7:0] rq[$];
    logic [31:0] seed = 32'hf27f;
    int bad_count = 0;
    int cmp_count = 0;

    // System clock
    always #25 clk_sys = ~clk_sys;

    dvc_core dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .samp_valid(samp_valid), .samp_ready(samp_ready),
        .samp_data(samp_data), .wclk_pin(wclk_pin), .left_gain(8'h00),
        .soft_step(soft_step), .out_data(out_data), .out_valid(out_valid),
        .drc_active(drc_active));
    dvc_host_model host_u (.clk_sys(clk_sys), .samp_ready(samp_ready),
        .samp_valid(samp_valid), .samp_data(samp_data), .wclk_pin(wclk_pin));

    // Compare and count
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Xorshift source, even samples below 2^17
    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {{7{seed[16]}}, seed[16:1], 1'b0};
    endfunction : rnd

    // Register write, one-cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    // Register read, expected value noted first
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
    endtask : rd

    // One frame through one word clock; left channel stays at unity
    task automatic fr(input logic [23:0] s, input logic [23:0] e, input logic c);
        host_u.push({s, s});
        dq.push_back({c, s, e});
        host_u.tick();
    endtask : fr

    // Unchecked frames
    task automatic run(input int n);
        repeat (n) fr(rnd(), 24'h0, 1'b0);
    endtask : run

    // Jump to a gain, then check scaled samples
    task automatic gt(input logic [7:0] g, input int sh);
        logic [23:0] s;
        wr(dvc_pkg::ADDR_RGAIN, g);
        rd(dvc_pkg::ADDR_RGAIN, g);
        run(1);
        repeat (3) begin
            s = rnd();
            fr(s, (sh < 0) ? 24'($signed(s) >>> 1) : 24'(s << sh), 1'b1);
        end
    endtask : gt

    // Result watchers take the oldest note
    always @(negedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            chk(48'(reg_rdata), 48'(rq.pop_front()));
        end
        if (out_valid === 1'b1) begin
            nt = dq.pop_front();
            if (nt.chk) begin
                chk(out_data, nt.f);
            end
        end
    end

    // Main sequence
    initial begin
        logic [23:0] s;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        rd(dvc_pkg::ADDR_RGAIN, 8'h00);
        rd(dvc_pkg::ADDR_CTL1, 8'h0f);
        rd(dvc_pkg::ADDR_CTL2, 8'h38);
        rd(8'h43, 8'h00);
        for (int i = 0; i < 32; i++) begin
            wr(dvc_pkg::ADDR_CTL1, 8'(i) | 8'h80);
            rd(dvc_pkg::ADDR_CTL1, 8'(i));
        end
        for (int i = 0; i < 16; i++) begin
            wr(dvc_pkg::ADDR_CTL2, 8'(i << 3) | 8'h87);
            rd(dvc_pkg::ADDR_CTL2, 8'(i << 3));
        end
        gt(8'hf4, -1);
        gt(8'h18, 2);
        gt(8'h30, 4);
        fr(24'h200000, 24'h7fffff, 1'b1);
        fr(24'he00000, 24'h800000, 1'b1);
        chk(48'(drc_active), 48'h0);
        gt(8'h00, 0);
        for (int i = 0; i < 8; i++) begin
            s = rnd();
            host_u.push({s, s});
            dq.push_back({1'b1, s, s});
        end
        chk(48'(samp_ready), 48'h0);
        repeat (8) host_u.tick();
        fr(24'h0, 24'h0, 1'b0);
        dq.push_back({1'b1, 48'h0});
        host_u.tick();
        soft_step = 2'b00;
        wr(dvc_pkg::ADDR_RGAIN, 8'h18);
        run(12);
        s = rnd();
        fr(s, s << 1, 1'b1);
        run(11);
        s = rnd();
        fr(s, s << 2, 1'b1);
        soft_step = 2'b01;
        wr(dvc_pkg::ADDR_RGAIN, 8'h00);
        run(24);
        s = rnd();
        fr(s, s << 1, 1'b1);
        soft_step = 2'b10;
        run(2);
        wr(dvc_pkg::ADDR_CTL2, 8'h08);
        wr(dvc_pkg::ADDR_CTL1, 8'h23);
        repeat (2) fr(24'h7fffff, 24'h0, 1'b0);
        chk(48'(drc_active), 48'h2);
        run(28);
        chk(48'(drc_active), 48'h2);
        run(12);
        chk(48'(drc_active), 48'h0);
        wr(dvc_pkg::ADDR_CTL2, 8'h00);
        wr(dvc_pkg::ADDR_CTL1, 8'h63);
        repeat (2) fr(24'h7fffff, 24'h0, 1'b0);
        chk(48'(drc_active), 48'h3);
        run(4);
        chk(48'(drc_active), 48'h0);
        repeat (10) @(posedge clk_sys);
        chk(48'(dq.size() + rq.size()), 48'h0);
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end
endmodule : dvc_core_tb
